/* File: src/dpm_top.sv */
// Debug probe multiplexer with an AXI4-Lite register slave.
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "dpm_map.svh"
module dpm_top (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire dpm_pkg::dpm_axi_req_t axi_req,
  output var  dpm_pkg::dpm_axi_rsp_t axi_rsp,
  input  wire dpm_pkg::dpm_probe_t   probe,
  input  wire logic                  rf_carrier,
  output logic [`DPM_PADS-1:0]       pad_probe,
  output logic [`DPM_PADS-1:0]       pad_claim,
  output logic [3:0]                 first_auxiliary_pin_ana_sel,
  output logic [3:0]                 second_auxiliary_pin_ana_sel,
  output logic                       first_auxiliary_pin_ana_en,
  output logic                       second_auxiliary_pin_ana_en,
  output logic                       busy
);
  import dpm_pkg::*;

  function automatic logic probe_bit(
    input logic [7:0] grp,
    input logic [3:0] sel,
    input dpm_probe_t p,
    input logic       clk
  );
    logic [7:0] v;
    v = 8'h00;
    case (grp)
      // RL2 timer group map
      `DPM_GRP_TIMER:
        v = {p.tmr_run[0], p.tmr_exp[0], p.tmr_run[1], p.tmr_exp[1],
             p.tmr_run[2], p.tmr_exp[2], 2'h0};
      // RL3 RL4 card group map
      `DPM_GRP_CARD:
        v = {p.cm_clk_fail, p.cm_type_a, p.cm_m212, p.cm_m424,
             p.cm_type_b, p.cm_eof, p.cm_data, p.cm_valid};
      // RL5 RL6 transceive group map
      `DPM_GRP_TRX:
        v = {p.trx_fetch_done, p.trx_fetch_req, p.trx_tx_start,
             p.trx_rx_en, p.trx_wait_exp, p.trx_state};
      // RL7 RL8 receive data group map
      `DPM_GRP_RXD:
        v = {p.rxd_coll, p.rxd_eod, p.rxd_valid, p.rxd_data,
             p.rxd_active, p.rxd_receiving, p.rxd_chain_rst, p.rxd_bitclk};
      // RL9 RL10 receive error group map
      `DPM_GRP_RXE:
        v = {p.rxe_any, p.rxe_multi_len, 3'h0,
             p.rxe_coll, p.rxe_proto, p.rxe_integrity};
      default:
        v = 8'h00;
    endcase
    // RL1 RL21 carrier and reserved codes
    if (sel == `DPM_SEL_CARRIER)
      probe_bit = clk;
    else if (sel > `DPM_SEL_CARRIER)
      probe_bit = 1'b0;
    else
      probe_bit = v[sel[2:0]];
  endfunction : probe_bit

  // RL14 RL15 RL16 RL17 valid analog codes
  function automatic logic ana_ok(input logic [7:0] code);
    ana_ok = (code <= `DPM_ANA_PRESENT) && (code != `DPM_ANA_RSVD);
  endfunction : ana_ok

  logic                  awready_ff;
  logic                  wready_ff;
  logic                  bvalid_ff;
  logic [1:0]            bresp_ff;
  logic                  arready_ff;
  logic                  rvalid_ff;
  logic [31:0]           rdata_ff;
  logic [1:0]            rresp_ff;
  logic                  aw_hold_ff;
  logic                  w_hold_ff;
  logic [7:0]            aw_addr_ff;
  logic [31:0]           w_data_ff;
  logic [3:0]            w_strb_ff;
  logic [7:0]            grp_ff;
  logic [31:0]           pos_ff;
  logic [7:0]            ana1_ff;
  logic [7:0]            ana2_ff;
  logic                  ana1_vld_ff;
  logic                  ana2_vld_ff;
  logic [7:0]            nv_cfg_ff;
  logic [7:0]            last_cmd_ff;
  logic [2:0]            busy_cnt_ff;
  logic                  busy_ff;
  logic [7:0]            pad_grp_ff [`DPM_PADS];
  logic [3:0]            pad_sel_ff [`DPM_PADS];
  logic [`DPM_PADS-1:0]  pad_vld_ff;
  logic [`DPM_PADS-1:0]  pad_probe_ff;
  logic [`DPM_PADS-1:0]  pad_claim_ff;
  logic [3:0]            first_auxiliary_pin_sel_ff;
  logic [3:0]            second_auxiliary_pin_sel_ff;
  logic                  first_auxiliary_pin_en_ff;
  logic                  second_auxiliary_pin_en_ff;
  logic                  rf_s1_ff;
  logic                  rf_s2_ff;
  logic                  rf_s3_ff;
  logic                  clk13_ff;

  wire aw_take = axi_req.awvalid & awready_ff;
  wire w_take  = axi_req.wvalid & wready_ff;
  wire ar_take = axi_req.arvalid & arready_ff;
  wire do_wr   = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = aw_take | (aw_hold_ff & ~do_wr);
  wire nxt_w_hold  = w_take | (w_hold_ff & ~do_wr);
  wire nxt_bvalid  = do_wr | (bvalid_ff & ~axi_req.bready);
  wire nxt_rvalid  = ar_take | (rvalid_ff & ~axi_req.rready);

  wire wr_group = do_wr & (aw_addr_ff == `DPM_REG_GROUP);
  wire wr_pos   = do_wr & (aw_addr_ff == `DPM_REG_POS);
  wire wr_ana   = do_wr & (aw_addr_ff == `DPM_REG_ANA);
  wire wr_nv    = do_wr & (aw_addr_ff == `DPM_REG_NVCFG);
  wire wr_hit   = wr_group | wr_pos | wr_ana | wr_nv |
                  (aw_addr_ff == `DPM_REG_STATUS);
  wire wr_cmd   = wr_pos | wr_ana;

  // RL20 enable bit of the configuration byte
  wire test_en = nv_cfg_ff[`DPM_NV_TEST_BIT];

  wire [7:0] ra = axi_req.araddr;
  wire rd_hit = (ra == `DPM_REG_GROUP) | (ra == `DPM_REG_POS) |
                (ra == `DPM_REG_ANA) | (ra == `DPM_REG_NVCFG) |
                (ra == `DPM_REG_STATUS);
  wire [31:0] st_word = {16'h0000, last_cmd_ff, pad_claim_ff,
                         2'h0, busy_ff, test_en};
  wire [31:0] rd_word =
    (ra == `DPM_REG_GROUP)  ? {24'h000000, grp_ff} :
    (ra == `DPM_REG_POS)    ? pos_ff :
    (ra == `DPM_REG_ANA)    ? {16'h0000, ana1_ff, ana2_ff} :
    (ra == `DPM_REG_NVCFG)  ? {24'h000000, nv_cfg_ff} :
    (ra == `DPM_REG_STATUS) ? st_word : 32'h00000000;

  logic [`DPM_PADS-1:0] nxt_pad_probe;
  genvar gi;
  generate
    for (gi = 0; gi < `DPM_PADS; gi++)
    begin : g_pad
      // RL12 pads stay low without test enable
      assign nxt_pad_probe[gi] = test_en & pad_vld_ff[gi] &
        probe_bit(pad_grp_ff[gi], pad_sel_ff[gi], probe, clk13_ff);
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
    end
    else
    begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff  <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold & ~nxt_bvalid;
      wready_ff  <= ~nxt_w_hold & ~nxt_bvalid;
      bvalid_ff  <= nxt_bvalid;
      arready_ff <= ~nxt_rvalid & ~ar_take;
      rvalid_ff  <= nxt_rvalid;
    end
  end

  // Payload registers need no reset; they are only read behind a valid.
  always_ff @(posedge ref_clk)
  begin
    if (aw_take)
      aw_addr_ff <= axi_req.awaddr;
    if (w_take)
    begin
      w_data_ff <= axi_req.wdata;
      w_strb_ff <= axi_req.wstrb;
    end
    if (do_wr)
      bresp_ff <= wr_hit ? `DPM_RESP_OKAY : `DPM_RESP_SLVERR;
    if (ar_take)
    begin
      rdata_ff <= rd_word;
      rresp_ff <= rd_hit ? `DPM_RESP_OKAY : `DPM_RESP_SLVERR;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      grp_ff      <= 8'h00;
      pos_ff      <= 32'h00000000;
      ana1_ff     <= `DPM_ANA_DAC;
      ana2_ff     <= `DPM_ANA_DAC;
      ana1_vld_ff <= 1'b0;
      ana2_vld_ff <= 1'b0;
      nv_cfg_ff   <= `DPM_NV_RESET;
      last_cmd_ff <= 8'h00;
      pad_vld_ff  <= '0;
      for (int i = 0; i < `DPM_PADS; i++)
      begin
        pad_grp_ff[i] <= 8'h00;
        pad_sel_ff[i] <= 4'h0;
      end
    end
    else
    begin
      if (wr_group && w_strb_ff[0])
        grp_ff <= w_data_ff[7:0];
      if (wr_nv && w_strb_ff[0])
        nv_cfg_ff <= w_data_ff[7:0];
      if (wr_pos)
      begin
        pos_ff      <= w_data_ff;
        last_cmd_ff <= `DPM_CMD_DIGITAL;
        // RL19 RL18 each strobed byte claims its pad
        for (int b = 0; b < 4; b++)
        begin
          if (w_strb_ff[b] && w_data_ff[8*b+4 +: 4] < 4'(`DPM_PADS))
          begin
            pad_vld_ff[w_data_ff[8*b+4 +: 2]] <= 1'b1;
            pad_grp_ff[w_data_ff[8*b+4 +: 2]] <= grp_ff;
            pad_sel_ff[w_data_ff[8*b+4 +: 2]] <= w_data_ff[8*b +: 4];
            if (w_data_ff[8*b+4 +: 2] == `DPM_PAD_FIRST_AUXILIARY_PIN)
              ana1_vld_ff <= 1'b0;
            if (w_data_ff[8*b+4 +: 2] == `DPM_PAD_SECOND_AUXILIARY_PIN)
              ana2_vld_ff <= 1'b0;
          end
        end
      end
      if (wr_ana)
      begin
        last_cmd_ff <= `DPM_CMD_ANALOG;
        // RL11 low byte is the second pin, next byte the first
        if (w_strb_ff[0])
        begin
          ana2_ff                  <= w_data_ff[7:0];
          ana2_vld_ff              <= 1'b1;
          pad_vld_ff[`DPM_PAD_SECOND_AUXILIARY_PIN] <= 1'b0;
        end
        if (w_strb_ff[1])
        begin
          ana1_ff                  <= w_data_ff[15:8];
          ana1_vld_ff              <= 1'b1;
          pad_vld_ff[`DPM_PAD_FIRST_AUXILIARY_PIN] <= 1'b0;
        end
      end
    end
  end

  // RL13 busy rises after every command so the host can pace itself
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_cnt_ff <= 3'h0;
      busy_ff     <= 1'b0;
    end
    else if (wr_cmd)
    begin
      busy_cnt_ff <= `DPM_BUSY_CYC;
      busy_ff     <= 1'b1;
    end
    else
    begin
      busy_cnt_ff <= (busy_cnt_ff != 3'h0) ? busy_cnt_ff - 3'h1 : 3'h0;
      busy_ff     <= busy_cnt_ff > 3'h1;
    end
  end

  // The carrier is sampled at 25 MHz, so the pad shows an aliased copy only.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rf_s1_ff <= 1'b0;
      rf_s2_ff <= 1'b0;
      rf_s3_ff <= 1'b0;
      clk13_ff <= 1'b0;
    end
    else
    begin
      rf_s1_ff <= rf_carrier;
      rf_s2_ff <= rf_s1_ff;
      rf_s3_ff <= rf_s2_ff;
      if (rf_s2_ff == rf_s3_ff)
        clk13_ff <= rf_s3_ff;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pad_probe_ff <= '0;
      pad_claim_ff <= '0;
      first_auxiliary_pin_sel_ff  <= 4'h0;
      second_auxiliary_pin_sel_ff  <= 4'h0;
      first_auxiliary_pin_en_ff   <= 1'b0;
      second_auxiliary_pin_en_ff   <= 1'b0;
    end
    else
    begin
      pad_probe_ff <= nxt_pad_probe;
      // RL12 claims and analog routes need test enable
      pad_claim_ff <= pad_vld_ff & {`DPM_PADS{test_en}};
      first_auxiliary_pin_sel_ff  <= ana1_ff[3:0];
      second_auxiliary_pin_sel_ff  <= ana2_ff[3:0];
      // RL21 reserved analog codes leave the pin undriven
      first_auxiliary_pin_en_ff   <= test_en & ana1_vld_ff & ana_ok(ana1_ff);
      second_auxiliary_pin_en_ff   <= test_en & ana2_vld_ff & ana_ok(ana2_ff);
    end
  end

  assign axi_rsp.awready = awready_ff;
  assign axi_rsp.wready  = wready_ff;
  assign axi_rsp.bvalid  = bvalid_ff;
  assign axi_rsp.bresp   = bresp_ff;
  assign axi_rsp.arready = arready_ff;
  assign axi_rsp.rvalid  = rvalid_ff;
  assign axi_rsp.rdata   = rdata_ff;
  assign axi_rsp.rresp   = rresp_ff;
  assign pad_probe       = pad_probe_ff;
  assign pad_claim       = pad_claim_ff;
  assign first_auxiliary_pin_ana_sel    = first_auxiliary_pin_sel_ff;
  assign second_auxiliary_pin_ana_sel    = second_auxiliary_pin_sel_ff;
  assign first_auxiliary_pin_ana_en     = first_auxiliary_pin_en_ff;
  assign second_auxiliary_pin_ana_en     = second_auxiliary_pin_en_ff;
  assign busy            = busy_ff;
endmodule : dpm_top
`default_nettype wire

/* File: src/dpm_map.svh */
// Register offsets, codes and reset values of the debug probe multiplexer.
// Contract
// RL1 - Selector 8 routes the carrier clock in every group; 9 to 15 reserved.
// RL2 - Timer group: 7,5,3 running flags T0..T2; 6,4,2 expiry flags; 1,0 reserved.
// RL3 - Card group: 7 clock fail; 6..3 Type A, 212k, 424k, Type B detection.
// RL4 - Card group: 2 end of frame, 1 decoded data, 0 data valid.
// RL5 - Transceive: 7 prefetch done, 6 prefetch request, 5 tx start, 4 rx enable.
// RL6 - Transceive: 3 waiting time expired; 2..0 transceive state bits two..zero.
// RL7 - Receive data: 7..4 front collision, end of data, valid, received data.
// RL8 - Receive data: 3 rx status, 2 receiving, 1 chain reset, 0 bit clock.
// RL9 - Receive error: 7 combined error, 6 long multi-frame length; 5..3 reserved.
// RL10 - Receive error: 2 collision, 1 protocol error, 0 integrity error.
// RL11 - Analog command 0x19 carries second pin selector first, then first pin.
// RL12 - Nothing reaches any pad unless the nonvolatile test enable is set.
// RL13 - Host waits for busy high after the analog command.
// RL14 - Analog 0..4: DAC level, Q, I, filtered Q, filtered I.
// RL15 - Analog 5: adaptive bit detection threshold.
// RL16 - Analog 6 filtered correlation, 7 raw correlation, 8 reserved.
// RL17 - Analog 9 phase correlation sum, A subcarrier presence correlation.
// RL18 - Group codes: 1D timer, 30 card, 58 transceive, 70 rx data, 73 rx error.
// RL19 - Pad nibble: 0 interrupt, 1 first aux, 2 second aux, 3 general output.
// RL20 - Test enable is bit 7 of the configuration byte at address 0x17.
// RL21 - A reserved selector drives the chosen output constantly low.
`ifndef DPM_MAP_SVH
`define DPM_MAP_SVH
`define DPM_REG_GROUP   8'h00
`define DPM_REG_POS     8'h04
`define DPM_REG_ANA     8'h08
`define DPM_REG_NVCFG   8'h0C
`define DPM_REG_STATUS  8'h10
`define DPM_CMD_DIGITAL 8'h18
`define DPM_CMD_ANALOG  8'h19
`define DPM_NV_ADDR     8'h17
`define DPM_NV_TEST_BIT 7
`define DPM_NV_RESET    8'h00
`define DPM_GRP_TIMER   8'h1D
`define DPM_GRP_CARD    8'h30
`define DPM_GRP_TRX     8'h58
`define DPM_GRP_RXD     8'h70
`define DPM_GRP_RXE     8'h73
`define DPM_SEL_CARRIER 4'h8
`define DPM_PADS        4
`define DPM_PAD_FIRST_AUXILIARY_PIN    2'h1
`define DPM_PAD_SECOND_AUXILIARY_PIN    2'h2
`define DPM_ANA_DAC     8'h00
`define DPM_ANA_RSVD    8'h08
`define DPM_ANA_PRESENT 8'h0A
`define DPM_BUSY_CYC    3'h4
`define DPM_RESP_OKAY   2'h0
`define DPM_RESP_SLVERR 2'h2
`endif

/* File: src/dpm_pkg.sv */
// Types carried on the ports of the debug probe multiplexer.
package dpm_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } dpm_axi_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } dpm_axi_rsp_t;
  typedef struct packed {
    logic [2:0] tmr_run;
    logic [2:0] tmr_exp;
    logic       cm_clk_fail;
    logic       cm_type_a;
    logic       cm_m212;
    logic       cm_m424;
    logic       cm_type_b;
    logic       cm_eof;
    logic       cm_data;
    logic       cm_valid;
    logic       trx_fetch_done;
    logic       trx_fetch_req;
    logic       trx_tx_start;
    logic       trx_rx_en;
    logic       trx_wait_exp;
    logic [2:0] trx_state;
    logic       rxd_coll;
    logic       rxd_eod;
    logic       rxd_valid;
    logic       rxd_data;
    logic       rxd_active;
    logic       rxd_receiving;
    logic       rxd_chain_rst;
    logic       rxd_bitclk;
    logic       rxe_any;
    logic       rxe_multi_len;
    logic       rxe_coll;
    logic       rxe_proto;
    logic       rxe_integrity;
  } dpm_probe_t;
endpackage : dpm_pkg

/* File: sim/dpm_top_properties.sv */
// Concurrent checks on the ports of the debug probe multiplexer.
`timescale 1ns/100ps
`default_nettype none
`include "dpm_map.svh"
module dpm_checker
  import dpm_pkg::*;
(
  input wire logic                  ref_clk,
  input wire logic                  rst,
  input wire dpm_pkg::dpm_axi_req_t axi_req,
  input wire dpm_pkg::dpm_axi_rsp_t axi_rsp,
  input wire dpm_pkg::dpm_probe_t   probe,
  input wire logic                  rf_carrier,
  input wire logic [3:0]            pad_probe,
  input wire logic [3:0]            pad_claim,
  input wire logic [3:0]            first_auxiliary_pin_ana_sel,
  input wire logic [3:0]            second_auxiliary_pin_ana_sel,
  input wire logic                  first_auxiliary_pin_ana_en,
  input wire logic                  second_auxiliary_pin_ana_en,
  input wire logic                  busy
);
  // Shadow of the test enable; assumes address and data arrive together.
  logic      te_ff;
  wire logic wr_take = axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      te_ff <= 1'b0;
    else if (wr_take && axi_req.awaddr == `DPM_REG_NVCFG)
      te_ff <= axi_req.wdata[`DPM_NV_TEST_BIT];
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_TEST_GATE: assert property ((!te_ff)[*4] |-> pad_claim == 4'h0 && !first_auxiliary_pin_ana_en && !second_auxiliary_pin_ana_en)
    else $error("probe output while test enable is off");
  AST_BUSY_SPAN: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
    else $error("busy length wrong");
  AST_CMD_BUSY: assert property (wr_take && axi_req.awaddr == `DPM_REG_ANA |-> ##[1:3] busy)
    else $error("analog command did not raise busy");
  AST_B_HOLD: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped early");
  AST_R_TURN: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid && !axi_rsp.arready)
    else $error("read answer late");
  AST_W_TURN: assert property (wr_take |=> !axi_rsp.awready ##[0:1] axi_rsp.bvalid)
    else $error("write answer late");
  AST_ANA1_CODE: assert property (first_auxiliary_pin_ana_en |-> first_auxiliary_pin_ana_sel != 4'h8 && first_auxiliary_pin_ana_sel <= 4'hA)
    else $error("first aux routes a reserved analog code");
  AST_ANA2_CODE: assert property (second_auxiliary_pin_ana_en |-> second_auxiliary_pin_ana_sel != 4'h8 && second_auxiliary_pin_ana_sel <= 4'hA)
    else $error("second aux routes a reserved analog code");
  cover property ($rose(busy));
  cover property (pad_claim == 4'hF);
  cover property (first_auxiliary_pin_ana_en && second_auxiliary_pin_ana_en);
endmodule : dpm_checker
bind dpm_top dpm_checker dpm_checker_i (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .probe(probe), .rf_carrier(rf_carrier), .pad_probe(pad_probe), .pad_claim(pad_claim),
  .first_auxiliary_pin_ana_sel(first_auxiliary_pin_ana_sel), .second_auxiliary_pin_ana_sel(second_auxiliary_pin_ana_sel), .first_auxiliary_pin_ana_en(first_auxiliary_pin_ana_en),
  .second_auxiliary_pin_ana_en(second_auxiliary_pin_ana_en), .busy(busy));
`default_nettype wire

/* File: sim/dpm_host_model.sv */
// Host controller model issuing register cycles over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module dpm_host_model
(
  input  wire logic                  ref_clk,
  output var  dpm_pkg::dpm_axi_req_t axi_req,
  input  wire dpm_pkg::dpm_axi_rsp_t axi_rsp
);
  import dpm_pkg::*;
  initial axi_req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge ref_clk);
    axi_req.awaddr <= a;
    axi_req.wdata <= d;
    axi_req.wstrb <= st;
    axi_req.awvalid <= 1'b1;
    axi_req.wvalid <= 1'b1;
    axi_req.bready <= 1'b1;
    while (aw || w)
    begin
      @(posedge ref_clk);
      if (aw && axi_rsp.awready)
      begin
        aw = 1'b0;
        axi_req.awvalid <= 1'b0;
      end
      if (w && axi_rsp.wready)
      begin
        w = 1'b0;
        axi_req.wvalid <= 1'b0;
      end
    end
    while (!axi_rsp.bvalid)
      @(posedge ref_clk);
    r = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'b1;
    axi_req.rready <= 1'b1;
    do
      @(posedge ref_clk);
    while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    while (!axi_rsp.rvalid)
      @(posedge ref_clk);
    d = axi_rsp.rdata;
    r = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask : rd
endmodule : dpm_host_model
`default_nettype wire

/* File: sim/dpm_top_bench.sv */
// Self-checking bench of the debug probe multiplexer.
`timescale 1ns/100ps
`default_nettype none
`include "dpm_map.svh"
module dpm_top_bench;
  import dpm_pkg::*;
  logic         ref_clk;
  logic         rst;
  dpm_axi_req_t axi_req;
  dpm_axi_rsp_t axi_rsp;
  dpm_probe_t   probe;
  logic         rf_carrier;
  logic [3:0]   pad_probe;
  logic [3:0]   pad_claim;
  logic [3:0]   first_auxiliary_pin_ana_sel;
  logic [3:0]   second_auxiliary_pin_ana_sel;
  logic         first_auxiliary_pin_ana_en;
  logic         second_auxiliary_pin_ana_en;
  logic         busy;
  logic [1:0]   resp;
  logic [31:0]  rdat;
  int           err_total;
  int           cmp_count;
  int           cyc;
  // Rows: group code, then the probe bit index for selectors 0..7; FF marks a reserved code.
  localparam logic [7:0] GRP [5] = '{`DPM_GRP_TIMER, `DPM_GRP_CARD, `DPM_GRP_TRX, `DPM_GRP_RXD, `DPM_GRP_RXE};
  localparam logic [7:0] IDX [5][8] = '{
    '{8'hFF, 8'hFF, 8'h1F, 8'h22, 8'h1E, 8'h21, 8'h1D, 8'h20},
    '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C},
    '{8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14},
    '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C},
    '{8'h00, 8'h01, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h04}};
  dpm_top dpm_top_i (.ref_clk(ref_clk), .rst(rst), .axi_req(axi_req), .axi_rsp(axi_rsp), .probe(probe),
    .rf_carrier(rf_carrier), .pad_probe(pad_probe), .pad_claim(pad_claim), .first_auxiliary_pin_ana_sel(first_auxiliary_pin_ana_sel),
    .second_auxiliary_pin_ana_sel(second_auxiliary_pin_ana_sel), .first_auxiliary_pin_ana_en(first_auxiliary_pin_ana_en), .second_auxiliary_pin_ana_en(second_auxiliary_pin_ana_en), .busy(busy));
  dpm_host_model dpm_host_model_i (.ref_clk(ref_clk), .axi_req(axi_req), .axi_rsp(axi_rsp));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic probe_case(input int g, input logic [3:0] s);
    logic [7:0]  ix;
    logic [1:0]  pd;
    logic [34:0] oh;
    ix = (s < 4'h8) ? IDX[g][s[2:0]] : 8'hFF;
    pd = s[1:0];
    oh = (ix == 8'hFF) ? 35'h0 : (35'h1 << ix);
    dpm_host_model_i.wr(`DPM_REG_GROUP, {24'h0, GRP[g]}, 4'h1, resp);
    dpm_host_model_i.wr(`DPM_REG_POS, {24'h0, 2'h0, pd, s}, 4'h1, resp);
    probe <= dpm_probe_t'(oh);
    repeat (3) @(posedge ref_clk);
    chk(pad_claim[pd], 1'b1);
    chk(pad_probe[pd], ix != 8'hFF);
    probe <= dpm_probe_t'(~oh);
    repeat (3) @(posedge ref_clk);
    chk(pad_probe[pd], 1'b0);
  endtask : probe_case
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    // Whole run needs under a thousand cycles; this only catches a hung handshake.
    if (cyc == 30000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    rst = 1'b1;
    probe = '0;
    rf_carrier = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    dpm_host_model_i.rd(`DPM_REG_NVCFG, rdat, resp);
    chk(rdat, 32'h0);
    dpm_host_model_i.rd(8'h14, rdat, resp);
    chk(rdat, 32'h0);
    chk({30'h0, resp}, {30'h0, `DPM_RESP_SLVERR});
    dpm_host_model_i.wr(8'h40, 32'h0, 4'hF, resp);
    chk(resp, `DPM_RESP_SLVERR);
    dpm_host_model_i.wr(`DPM_REG_STATUS, 32'hFFFF_FFFF, 4'hF, resp);
    chk(resp, `DPM_RESP_OKAY);
    dpm_host_model_i.wr(`DPM_REG_NVCFG, 32'h7F, 4'h1, resp);
    // With the enable off a programmed pad must stay dark, so set it up and check it here.
    dpm_host_model_i.wr(`DPM_REG_GROUP, {24'h0, `DPM_GRP_TIMER}, 4'h1, resp);
    dpm_host_model_i.wr(`DPM_REG_POS, 32'h37, 4'h1, resp);
    probe <= dpm_probe_t'('1);
    repeat (3) @(posedge ref_clk);
    chk({pad_claim, pad_probe}, 8'h0);
    dpm_host_model_i.wr(`DPM_REG_NVCFG, 32'h80, 4'h1, resp);
    dpm_host_model_i.rd(`DPM_REG_STATUS, rdat, resp);
    chk(rdat[0], 1'b1);
    $display("test gate done");
    for (int g = 0; g < 5; g++)
      for (int s = 0; s < 10; s++)
        if (s != 8)
          probe_case(g, s[3:0]);
    $display("test digital done");
    dpm_host_model_i.wr(`DPM_REG_GROUP, {24'h0, `DPM_GRP_RXD}, 4'h1, resp);
    dpm_host_model_i.wr(`DPM_REG_POS, 32'h18, 4'h1, resp);
    for (int k = 0; k < 4; k++)
    begin
      rf_carrier <= k[0];
      repeat (8) @(posedge ref_clk);
      chk(pad_probe[1], k[0]);
    end
    $display("test carrier done");
    for (int c = 0; c < 11; c++)
    begin
      dpm_host_model_i.wr(`DPM_REG_ANA, {16'h0, 8'(c), 8'(10 - c)}, 4'h3, resp);
      while (!busy)
        @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      chk({first_auxiliary_pin_ana_sel, first_auxiliary_pin_ana_en}, {4'(c), c != 8});
      chk({second_auxiliary_pin_ana_sel, second_auxiliary_pin_ana_en}, {4'(10 - c), c != 2});
    end
    dpm_host_model_i.rd(`DPM_REG_STATUS, rdat, resp);
    chk(rdat[15:8], `DPM_CMD_ANALOG);
    dpm_host_model_i.wr(`DPM_REG_NVCFG, 32'h0, 4'h1, resp);
    repeat (4) @(posedge ref_clk);
    chk({first_auxiliary_pin_ana_en, second_auxiliary_pin_ana_en, pad_claim}, 6'h0);
    $display("test analog done");
    dpm_host_model_i.wr(`DPM_REG_NVCFG, 32'h80, 4'h1, resp);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({pad_claim, busy}, 5'h0);
    dpm_host_model_i.rd(`DPM_REG_NVCFG, rdat, resp);
    chk(rdat, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule : dpm_top_bench
`default_nettype wire
